// ### core/rifm_pkg.sv
// Package: selection codes, defaults and carrier types for the remote input function mapper
package rifm_pkg;
  localparam int NUM_BITS = 16;
  localparam int SEL_W = 6;
  localparam int DSEL_W = 6;
  // Selection codes
  localparam logic [5:0] CODE_NONE = 6'h00;
  localparam logic [5:0] CODE_POS_RUN = 6'h01;
  localparam logic [5:0] CODE_NEG_RUN = 6'h02;
  localparam logic [5:0] CODE_HOME = 6'h03;
  localparam logic [5:0] CODE_START = 6'h04;
  localparam logic [5:0] CODE_SEQ = 6'h05;
  localparam logic [5:0] CODE_PINCH = 6'h06;
  localparam logic [5:0] CODE_NINCH = 6'h07;
  localparam logic [5:0] CODE_DPOS0 = 6'h08;
  localparam logic [5:0] CODE_FREE = 6'h10;
  localparam logic [5:0] CODE_EXC = 6'h11;
  localparam logic [5:0] CODE_STOP = 6'h12;
  localparam logic [5:0] CODE_ALM = 6'h18;
  localparam logic [5:0] CODE_PRESET = 6'h19;
  localparam logic [5:0] CODE_PCLR = 6'h1a;
  localparam logic [5:0] CODE_PANEL = 6'h1b;
  localparam logic [5:0] CODE_FLAG0 = 6'h20;
  localparam logic [5:0] CODE_DSEL0 = 6'h30;
  // Default selection per remote bit, bit 0 in the low slot
  localparam logic [95:0] DEFAULT_SEL = {
    6'h02, 6'h01, 6'h07, 6'h06, 6'h05, 6'h0a, 6'h09, 6'h08,
    6'h00, 6'h10, 6'h12, 6'h03, 6'h04, 6'h32, 6'h31, 6'h30};
  localparam logic [15:0] RESET_IN = 16'h0000;

  // Motion level commands
  typedef struct packed {
    logic pos_run;
    logic neg_run;
    logic free;
    logic excite;
    logic stop;
  } rifm_level_s;

  // One-cycle start, preset and clear pulses
  typedef struct packed {
    logic home;
    logic start;
    logic seq;
    logic pinch;
    logic ninch;
    logic [5:0] dpos;
    logic alarm_clear;
    logic preset;
    logic pclr;
  } rifm_pulse_s;
endpackage

// ### core/rifm_edge.sv
// Per-function level edge detector
`timescale 1ns/1ps
module rifm_edge #(
  parameter int W = 14
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [W-1:0] level,
  output logic [W-1:0] rise,
  output logic [W-1:0] fall
);
  logic [W-1:0] prev;

  // Previous level, cleared by reset so a held level after reset is a rise
  always_ff @(posedge mclk)
  begin
    if (rst)
      prev <= '0;
    else
      prev <= level;
  end

  assign rise = level & ~prev;
  assign fall = ~level & prev;
endmodule

// ### core/rifm_mapper.sv
// Remote input function mapper: sixteen remote bits onto the driver's command functions
`timescale 1ns/1ps
module rifm_mapper #(
  parameter int NBITS = rifm_pkg::NUM_BITS,
  parameter logic [95:0] DEF_SEL = rifm_pkg::DEFAULT_SEL,
  parameter logic [35:0] DPOS_NUM = {6'h05, 6'h04, 6'h03, 6'h02, 6'h01, 6'h00}
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [15:0] remote_in,
  input wire logic sel_we,
  input wire logic [3:0] sel_index,
  input wire logic [5:0] sel_code,
  input wire logic post_change,
  input wire logic direct_exc_assigned,
  input wire logic direct_exc,
  input wire logic direct_panel_assigned,
  input wire logic direct_panel,
  output logic [5:0] op_data_num,
  output logic [15:0] general_flag,
  output rifm_pkg::rifm_level_s level_cmd,
  output rifm_pkg::rifm_pulse_s pulse_cmd,
  output logic [5:0] dpos_data_num,
  output logic panel_lockout_release,
  output logic sel_rejected
);
  logic [5:0] sel [16];
  logic [63:0] code_active;
  logic [5:0] next_op;
  logic [15:0] next_flag;
  logic [13:0] edge_lvl;
  logic [13:0] edge_rise;
  logic [13:0] edge_fall;
  logic [15:0] sel_hit;
  logic pos_run_lvl;
  logic neg_run_lvl;
  logic free_lvl;
  logic exc_remote_lvl;
  logic stop_lvl;
  logic home_lvl;
  logic start_lvl;
  logic seq_lvl;
  logic pinch_lvl;
  logic ninch_lvl;
  logic [5:0] dpos_lvl;
  logic alm_lvl;
  logic preset_lvl;
  logic pclr_lvl;
  logic panel_remote_lvl;
  logic exc_remote_on;
  logic exc_direct_on;
  logic panel_remote_on;
  logic panel_direct_on;
  logic any_dpos_rise;
  logic next_reject;
  rifm_pkg::rifm_level_s next_level;
  rifm_pkg::rifm_pulse_s next_pulse;
  logic exc_remote_assigned;
  logic panel_remote_assigned;
  logic next_exc;
  logic next_panel;
  logic [2:0] dpos_idx;
  logic [5:0] next_dpos_num;
  logic code_ok;

  // Functions needing the revised driver
  function automatic logic is_late_code(input logic [5:0] c);
    is_late_code = (c == rifm_pkg::CODE_ALM) || (c == rifm_pkg::CODE_PRESET) || (c == rifm_pkg::CODE_PCLR);
  endfunction

  // True if any remote bit selects code c
  function automatic logic is_assigned(input logic [5:0] c, input logic [95:0] s);
    is_assigned = 1'b0;
    for (int i = 0; i < 16; i++)
      if (s[i*6 +: 6] == c)
        is_assigned = 1'b1;
  endfunction

  // Codes the selection table knows; gaps in the code space are refused
  function automatic logic is_known_code(input logic [5:0] c);
    case (c)
      6'h0e, 6'h0f:
        is_known_code = 1'b0;
      6'h13, 6'h14, 6'h15, 6'h16, 6'h17:
        is_known_code = 1'b0;
      6'h1c, 6'h1d, 6'h1e, 6'h1f:
        is_known_code = 1'b0;
      default:
        is_known_code = (c <= rifm_pkg::CODE_DSEL0 + 6'h05);
    endcase
  endfunction

  // One-hot image of a selection code across the function space
  function automatic logic [63:0] code_onehot(input logic [5:0] c);
    code_onehot = 64'h1 << c;
  endfunction

  // Index of the lowest set bit of a six-bit vector, zero when none
  function automatic logic [2:0] lowest_set(input logic [5:0] v);
    lowest_set = 3'h0;
    for (int k = 5; k >= 0; k--)
      if (v[k])
        lowest_set = 3'(k);
  endfunction

  logic [95:0] sel_flat;
  always_comb
  begin
    for (int i = 0; i < 16; i++)
      sel_flat[i*6 +: 6] = sel[i];
  end

  // Write acceptance: unknown codes and late codes on old drivers refused
  assign code_ok = is_known_code(sel_code)
                   && !(is_late_code(sel_code) && !post_change);
  assign next_reject = sel_we && !code_ok;

  // One-hot write strobe per remote bit
  always_comb
  begin
    sel_hit = '0;
    if (sel_we && code_ok)
      sel_hit[sel_index] = 1'b1;
  end

  // Selection table, defaults loaded on reset
  always_ff @(posedge mclk)
  begin
    for (int i = 0; i < 16; i++)
      if (rst)
        sel[i] <= DEF_SEL[i*6 +: 6];
      else if (sel_hit[i])
        sel[i] <= sel_code;
  end

  // OR of all bits per code; code zero never reaches a function
  always_comb
  begin
    code_active = '0;
    for (int i = 0; i < 16; i++)
      code_active = code_active | (code_onehot(sel[i]) & {64{remote_in[i]}});
    code_active[0] = 1'b0;
    if (!post_change)
    begin
      code_active[rifm_pkg::CODE_ALM] = 1'b0;
      code_active[rifm_pkg::CODE_PRESET] = 1'b0;
      code_active[rifm_pkg::CODE_PCLR] = 1'b0;
    end
  end

  assign next_flag = code_active[47:32];
  assign next_op = code_active[53:48];

  // Named function levels after the bit merge
  assign pos_run_lvl = code_active[rifm_pkg::CODE_POS_RUN];
  assign neg_run_lvl = code_active[rifm_pkg::CODE_NEG_RUN];
  assign free_lvl = code_active[rifm_pkg::CODE_FREE];
  assign exc_remote_lvl = code_active[rifm_pkg::CODE_EXC];
  assign stop_lvl = code_active[rifm_pkg::CODE_STOP];
  assign home_lvl = code_active[rifm_pkg::CODE_HOME];
  assign start_lvl = code_active[rifm_pkg::CODE_START];
  assign seq_lvl = code_active[rifm_pkg::CODE_SEQ];
  assign pinch_lvl = code_active[rifm_pkg::CODE_PINCH];
  assign ninch_lvl = code_active[rifm_pkg::CODE_NINCH];
  assign dpos_lvl = code_active[rifm_pkg::CODE_DPOS0 +: 6];
  assign alm_lvl = code_active[rifm_pkg::CODE_ALM];
  assign preset_lvl = code_active[rifm_pkg::CODE_PRESET];
  assign pclr_lvl = code_active[rifm_pkg::CODE_PCLR];
  assign panel_remote_lvl = code_active[rifm_pkg::CODE_PANEL];

  // Start, preset and clear functions, all edge qualified; order matches the pulse carrier
  assign edge_lvl = {home_lvl, start_lvl, seq_lvl, pinch_lvl, ninch_lvl, dpos_lvl,
                     alm_lvl, preset_lvl, pclr_lvl};

  rifm_edge #(.W(14)) rifm_edge_inst (
    .mclk(mclk),
    .rst(rst),
    .level(edge_lvl),
    .rise(edge_rise),
    .fall(edge_fall)
  );

  // Excitation and panel release merge with direct I/O; an unassigned source counts as on
  assign exc_remote_assigned = is_assigned(rifm_pkg::CODE_EXC, sel_flat);
  assign panel_remote_assigned = is_assigned(rifm_pkg::CODE_PANEL, sel_flat);
  assign exc_remote_on = exc_remote_assigned ? exc_remote_lvl : 1'b1;
  assign exc_direct_on = direct_exc_assigned ? direct_exc : 1'b1;
  assign next_exc = exc_remote_on & exc_direct_on;
  assign panel_remote_on = panel_remote_assigned ? panel_remote_lvl : 1'b1;
  assign panel_direct_on = direct_panel_assigned ? direct_panel : 1'b1;
  assign next_panel = panel_remote_on & panel_direct_on;

  // Lowest rising direct-position code picks its preset data number, zero when none rises
  assign any_dpos_rise = |edge_rise[8:3];
  assign dpos_idx = lowest_set(edge_rise[8:3]);
  assign next_dpos_num = any_dpos_rise ? DPOS_NUM[dpos_idx*6 +: 6] : 6'h00;

  // Level commands follow their functions
  always_comb
  begin
    next_level.pos_run = pos_run_lvl;
    next_level.neg_run = neg_run_lvl;
    next_level.free = free_lvl;
    next_level.excite = next_exc;
    next_level.stop = stop_lvl;
  end

  // Starts and preset on rising edges, both clears on falling edges
  always_comb
  begin
    next_pulse.home = edge_rise[13];
    next_pulse.start = edge_rise[12];
    next_pulse.seq = edge_rise[11];
    next_pulse.pinch = edge_rise[10];
    next_pulse.ninch = edge_rise[9];
    next_pulse.dpos = edge_rise[8:3];
    next_pulse.alarm_clear = edge_fall[2];
    next_pulse.preset = edge_rise[1];
    next_pulse.pclr = edge_fall[0];
  end

  // Operation number and general flags
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      op_data_num <= '0;
      general_flag <= '0;
    end
    else
    begin
      op_data_num <= next_op;
      general_flag <= next_flag;
    end
  end

  // Direct-position data number and panel release level
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      dpos_data_num <= '0;
      panel_lockout_release <= 1'b0;
    end
    else
    begin
      dpos_data_num <= next_dpos_num;
      panel_lockout_release <= next_panel;
    end
  end

  // Level commands and one-cycle pulses
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      level_cmd <= '0;
      pulse_cmd <= '0;
    end
    else
    begin
      level_cmd <= next_level;
      pulse_cmd <= next_pulse;
    end
  end

  // Refused write flag, one cycle after the write
  always_ff @(posedge mclk)
  begin
    if (rst)
      sel_rejected <= 1'b0;
    else
      sel_rejected <= next_reject;
  end
endmodule

// ### testbench/rifm_host.sv
// Host model: sends the remote input word
`timescale 1ns/1ps
module rifm_host (
  input wire logic mclk,
  input wire logic [15:0] word,
  output logic [15:0] remote_in
);
  logic [15:0] held = 16'h0000;
  // New word at the falling edge, duplicates allowed
  always @(negedge mclk) held <= word;
  assign remote_in = held;
endmodule

// ### testbench/rifm_mapper_properties.sv
// Port checks for the remote input function mapper
`timescale 1ns/1ps
module rifm_mapper_properties (
  input wire logic mclk,
  input wire logic rst,
  input wire logic sel_we,
  input wire logic [5:0] sel_code,
  input wire logic post_change,
  input wire rifm_pkg::rifm_pulse_s pulse_cmd,
  input wire logic [5:0] dpos_data_num,
  input wire logic sel_rejected
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);
  // Codes the table refuses
  wire bad = sel_code inside {[6'h0e:6'h0f], [6'h13:6'h17], [6'h1c:6'h1f], [6'h36:6'h3f]}
    || (!post_change && sel_code inside {[6'h18:6'h1a]});
  sequence wr_bad;
    sel_we && bad;
  endsequence
  sequence wr_ok;
    sel_we && !bad;
  endsequence
  refuse_bad_a: assert property (wr_bad |=> sel_rejected) else $error("no refusal");
  accept_ok_a: assert property (wr_ok |=> !sel_rejected) else $error("bad refusal");
  start_once_a: assert property (pulse_cmd.start |=> !pulse_cmd.start) else $error("long start");
  alarm_once_a: assert property (pulse_cmd.alarm_clear |=> !pulse_cmd.alarm_clear) else $error("long alarm");
  pclr_once_a: assert property (pulse_cmd.pclr |=> !pulse_cmd.pclr) else $error("long clear");
  preset_once_a: assert property (pulse_cmd.preset |=> !pulse_cmd.preset) else $error("long preset");
  pre_change_a: assert property (!$past(post_change) |-> !pulse_cmd.preset) else $error("preset early");
  dpos_idle_a: assert property (pulse_cmd.dpos == 6'h00 |-> dpos_data_num == 6'h00) else $error("stray num");
  reset_clear_a: assert property (disable iff (1'h0) rst |=> pulse_cmd == 0 && !sel_rejected)
    else $error("not cleared");
endmodule
bind rifm_mapper rifm_mapper_properties rifm_mapper_properties_inst (.mclk(mclk), .rst(rst), .sel_we(sel_we),
  .sel_code(sel_code), .post_change(post_change), .pulse_cmd(pulse_cmd), .dpos_data_num(dpos_data_num),
  .sel_rejected(sel_rejected));

// ### testbench/rifm_mapper_bench.sv
// Random self-checking bench for the remote input function mapper
`timescale 1ns/1ps
module rifm_mapper_bench;
  logic mclk = 1'h0, rst = 1'h1, we = 1'h0, pc = 1'h0, xa = 1'h0, xd = 1'h0, pa = 1'h0, pd = 1'h0;
  logic [15:0] word = 16'h0000, rin, gf;
  logic [3:0] idx = 4'h0;
  logic [5:0] code = 6'h00, opn, dpn;
  logic pr, rej;
  rifm_pkg::rifm_level_s lv;
  rifm_pkg::rifm_pulse_s pu;
  logic [63:0] prv = '0;
  logic [5:0] sel [16] = '{6'h30, 6'h31, 6'h32, 6'h04, 6'h03, 6'h12, 6'h10, 6'h00,
    6'h08, 6'h09, 6'h0a, 6'h05, 6'h06, 6'h07, 6'h01, 6'h02};
  int seed = 46550, bad_count = 0, checks_done = 0;
  initial forever #50 mclk = ~mclk;
  rifm_host rifm_host_inst (.mclk(mclk), .word(word), .remote_in(rin));
  rifm_mapper rifm_mapper_inst (.mclk(mclk), .rst(rst), .remote_in(rin), .sel_we(we), .sel_index(idx),
    .sel_code(code), .post_change(pc), .direct_exc_assigned(xa), .direct_exc(xd), .direct_panel_assigned(pa),
    .direct_panel(pd), .op_data_num(opn), .general_flag(gf), .level_cmd(lv), .pulse_cmd(pu),
    .dpos_data_num(dpn), .panel_lockout_release(pr), .sel_rejected(rej));
  // Function levels from the table
  function automatic logic [63:0] lvls(logic [15:0] r);
    logic [63:0] f;
    f = '0;
    for (int i = 0; i < 16; i++) f[sel[i]] |= r[i];
    f[0] = 1'h0;
    if (!pc) f[26:24] = 3'h0;
    return f;
  endfunction
  function automatic logic bad(logic [5:0] c);
    return c inside {[6'h0e:6'h0f], [6'h13:6'h17], [6'h1c:6'h1f], [6'h36:6'h3f]} || (!pc && c inside {[6'h18:6'h1a]});
  endfunction
  task automatic chk(logic [63:0] s, logic [63:0] e);
    checks_done++;
    if (s !== e)
    begin
      bad_count++;
      $display("Error at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic stop_test();
    $display("Checks %0d, mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // Compare every output against the model, then take the write
  task automatic step();
    logic [63:0] f, p, up, dn;
    logic [5:0] e;
    f = lvls(rin);
    p = lvls(16'hffff);
    up = f & ~prv;
    dn = prv & ~f;
    e = 6'h00;
    for (int j = 5; j >= 0; j--)
      if (up[8 + j]) e = 6'(j);
    chk(opn, f[53:48]);
    chk(gf, f[47:32]);
    chk(lv, {f[1], f[2], f[16], (f[17] | !p[17]) & (xd | !xa), f[18]});
    chk(pr, (f[27] | !p[27]) & (pd | !pa));
    chk(pu, {up[3], up[4], up[5], up[6], up[7], up[13:8], dn[24], up[25], dn[26]});
    chk(dpn, e);
    chk(rej, we & bad(code));
    if (we && !bad(code)) sel[idx] = code;
    prv = f;
  endtask
  // Defaults first, then random writes; a refused code 24 at cycle 40
  initial
  begin
    repeat (5) @(negedge mclk);
    rst <= 1'h0;
    for (int n = 0; n < 600; n++)
    begin
      @(negedge mclk);
      step();
      word <= 16'($random(seed));
      we <= n == 40 || (n > 40 && $random(seed) % 4 == 0);
      idx <= 4'($random(seed));
      code <= n == 40 ? 6'h18 : 6'($random(seed));
      pc <= n > 300;
      {xa, xd, pa, pd} <= 4'($random(seed));
    end
    stop_test();
  end
  // Watchdog
  initial
  begin
    #200000;
    bad_count++;
    stop_test();
  end
endmodule
